// *** tb/oneshot_pulse_and_width_capture_test.sv ***
// Purpose: self-checking bench of the one-shot and width-capture timer
// Assumes: prescale 0, so the count ticks once per clock
// Notes:   compare values 3 and 6 drive the one-shot cases
`timescale 1ns/1ps
`include "osw_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module oneshot_pulse_and_width_capture_test;
    logic        ref_clk = 1'b0;     // 25 MHz clock
    logic        reset_n = 1'b0;     // active-low reset
    logic [3:0]  address = 4'h0;     // word index
    logic        read    = 1'b0;     // read strobe
    logic        write   = 1'b0;     // write strobe
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        lvl0 = 1'b0;        // asked level of input 0
    logic        lvl1 = 1'b0;        // asked level of input 1
    logic        capture_input_0;
    logic        capture_input_1;
    logic        timer_output_pin;
    logic        irq_ch0;
    logic        irq_ch1;
    logic [31:0] rd_q;               // last read word
    logic [31:0] a_q;                // saved word
    int fails = 0;
    int comparisons = 0;
    int n0 = 0;                      // irq 0 pulses seen
    int n1 = 0;                      // irq 1 pulses seen
    int np = 0;                      // cycles with the pin high
    int s0, s1, sp, i, k;
    logic [31:0] md [3] = '{32'h0000_0000, 32'h0000_000C, 32'h0000_0004};
    logic [31:0] oc [3] = '{32'h0000_0061, 32'h0000_0061, 32'h0000_0041};
    // --------------------------------
    // clock and event tallies
    // --------------------------------
    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        n0 += int'(irq_ch0 === 1'b1);
        n1 += int'(irq_ch1 === 1'b1);
        np += int'(timer_output_pin === 1'b1);
    end
    osw_timer u_osw_timer (.ref_clk(ref_clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .capture_input_0(capture_input_0), .capture_input_1(capture_input_1),
        .timer_output_pin(timer_output_pin), .irq_ch0(irq_ch0), .irq_ch1(irq_ch1));
    osw_src u_osw_src (.ref_clk(ref_clk), .lvl0(lvl0), .lvl1(lvl1),
        .capture_input_0(capture_input_0), .capture_input_1(capture_input_1));
    // --------------------------------
    // bus cycles: hold until waitrequest is sampled low
    // --------------------------------
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        read <= ~w;
        write <= w;
        address <= a;
        writedata <= d;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0) @(posedge ref_clk);
        rd_q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic give_verdict;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // --------------------------------
    // watchdog against a hung wait
    // --------------------------------
    initial
    begin
        tick(90000);
        fails++;
        give_verdict();
    end
    // --------------------------------
    // test sequence
    // --------------------------------
    initial
    begin
        tick(16);
        reset_n <= 1'b1;
        tick(3);
        rd(`OSW_IDX_MODE);
        `CHK(rd_q, 32'h0000_0000)
        rd(4'h8);
        `CHK(rd_q, 32'h0000_0000)
        wr(`OSW_IDX_COUNT, 32'h0000_1234);
        rd(`OSW_IDX_COUNT);
        `CHK(rd_q, 32'h0000_0000)
        wr(`OSW_IDX_CC0, 32'h0000_0003);
        wr(`OSW_IDX_CC1, 32'h0000_0006);
        wr(`OSW_IDX_MODE, 32'h0000_0004);
        rd(`OSW_IDX_COUNT);
        a_q = rd_q;
        rd(`OSW_IDX_COUNT);
        `CHK(rd_q - a_q, 32'h0000_0003)
        // soft trigger: pin rises M+1 ticks after the write lands, stays N-M ticks
        wr(`OSW_IDX_OUTCTL, 32'h0000_0021);
        s0 = n0;
        s1 = n1;
        wr(`OSW_IDX_OUTCTL, 32'h0000_0061);
        for (i = 1; i <= 10; i++)
        begin
            @(posedge ref_clk);
            #1;
            `CHK(timer_output_pin, (i >= 4 && i < 7))
        end
        `CHK(n0 - s0, 1)
        `CHK(n1 - s1, 1)
        // input 0 valid edge as trigger
        wr(`OSW_IDX_EDGE, 32'h0000_0001);
        sp = np;
        tick(1);
        lvl0 <= 1'b1;
        tick(20);
        `CHK(np - sp, 3)
        // no pulse in stop, compare-clear or with one-shot disabled
        for (k = 0; k < 3; k++)
        begin
            wr(`OSW_IDX_MODE, md[k]);
            sp = np;
            wr(`OSW_IDX_OUTCTL, oc[k]);
            tick(20);
            `CHK(np - sp, 0)
        end
        // plain compare mode from a stopped, zeroed counter: invert bits toggle at each match
        wr(`OSW_IDX_OUTCTL, 32'h0000_0013);
        wr(`OSW_IDX_MODE, 32'h0000_0000);
        sp = np;
        s0 = n0;
        wr(`OSW_IDX_MODE, 32'h0000_0004);
        tick(20);
        `CHK(np - sp, 3)
        `CHK(n0 - s0, 1)
        // two-input width capture, both edges selected on both inputs, only rising edges driven
        wr(`OSW_IDX_MODE, 32'h0000_0000);
        lvl0 <= 1'b0;
        wr(`OSW_IDX_OUTCTL, 32'h0000_0000);
        wr(`OSW_IDX_CCCTL, 32'h0000_0005);
        wr(`OSW_IDX_EDGE, 32'h0000_000A);
        wr(`OSW_IDX_MODE, 32'h0000_0004);
        s0 = n0;
        s1 = n1;
        tick(1);
        lvl0 <= 1'b1;
        tick(10);
        lvl1 <= 1'b1;
        tick(10);
        rd(`OSW_IDX_CC1);
        a_q = rd_q;
        rd(`OSW_IDX_CC0);
        `CHK(rd_q[15:0] - a_q[15:0], 16'h000A)
        `CHK(n1 - s1, 1)
        `CHK(n0 - s0, 1)
        // single input: opposite edge to reg 0 with no irq
        wr(`OSW_IDX_MODE, 32'h0000_0000);
        lvl0 <= 1'b0;
        wr(`OSW_IDX_CCCTL, 32'h0000_0007);
        wr(`OSW_IDX_EDGE, 32'h0000_0001);
        wr(`OSW_IDX_MODE, 32'h0000_0004);
        s0 = n0;
        s1 = n1;
        tick(1);
        lvl0 <= 1'b1;
        tick(10);
        lvl0 <= 1'b0;
        tick(10);
        rd(`OSW_IDX_CC1);
        a_q = rd_q;
        rd(`OSW_IDX_CC0);
        `CHK(rd_q[15:0] - a_q[15:0], 16'h000A)
        `CHK(n0 - s0, 0)
        `CHK(n1 - s1, 1)
        // mode 10: valid edge captures, then clears the count
        wr(`OSW_IDX_MODE, 32'h0000_0008);
        tick(40);
        lvl0 <= 1'b1;
        tick(4);
        rd(`OSW_IDX_COUNT);
        `CHK(rd_q < 32'd12, 1'b1)
        rd(`OSW_IDX_CC1);
        `CHK(rd_q >= 32'd40, 1'b1)
        // wrap sets the sticky overflow flag, a write of 0 clears it
        wr(`OSW_IDX_MODE, 32'h0000_0004);
        tick(65600);
        rd(`OSW_IDX_MODE);
        `CHK(rd_q[0], 1'b1)
        wr(`OSW_IDX_MODE, 32'h0000_0004);
        rd(`OSW_IDX_MODE);
        `CHK(rd_q[3:0], 4'h4)
        give_verdict();
    end
endmodule

// *** tb/osw_src.sv ***
// Purpose: far-side pulse sources that drive the two capture inputs
// Assumes: the bench asks for new levels just after a rising edge
// Notes:   levels move only on request, so input 0 stays quiet between triggers
`timescale 1ns/1ps
module osw_src
(
    input  wire logic ref_clk,
    input  wire logic lvl0,
    input  wire logic lvl1,
    output logic      capture_input_0,
    output logic      capture_input_1
);
    // --------------------------------
    // registered source levels
    // --------------------------------
    initial
    begin
        capture_input_0 = 1'b0;
        capture_input_1 = 1'b0;
    end
    // each level holds for as long as the bench asks, many count ticks wide
    always @(posedge ref_clk)
    begin
        capture_input_0 <= lvl0;
        capture_input_1 <= lvl1;
    end
endmodule

// *** verilog/osw_cfg.svh ***
// Purpose: offsets, field positions, mode codes, count limits and reset values of the one-shot / width-capture timer
// Assumes: included by the timer top and its package users; definitions only
// Notes:   word index times four gives the Avalon byte address
`ifndef OSW_CFG_SVH
`define OSW_CFG_SVH

// ------------------------------------------------------------
// register word indices
// ------------------------------------------------------------
`define OSW_IDX_MODE    4'h0
`define OSW_IDX_CCCTL   4'h1
`define OSW_IDX_OUTCTL  4'h2
`define OSW_IDX_EDGE    4'h3
`define OSW_IDX_PRESC   4'h4
`define OSW_IDX_COUNT   4'h5
`define OSW_IDX_CC0     4'h6
`define OSW_IDX_CC1     4'h7

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define OSW_MODE_OVF_BIT   0
`define OSW_MODE_LO_BIT    2
`define OSW_CC_CAP0_BIT    0
`define OSW_CC_SRC0_BIT    1
`define OSW_CC_CAP1_BIT    2
`define OSW_OC_PINEN_BIT   0
`define OSW_OC_INV0_BIT    1
`define OSW_OC_INV1_BIT    4
`define OSW_OC_OSEN_BIT    5
`define OSW_OC_OSTRG_BIT   6

// ------------------------------------------------------------
// values
// ------------------------------------------------------------
`define OSW_MODE_STOP    2'h0
`define OSW_MODE_FREE    2'h1
`define OSW_MODE_IN0CLR  2'h2
`define OSW_MODE_CMPCLR  2'h3
`define OSW_CNT_MAX      16'hFFFF
`define OSW_CNT_ZERO     16'h0000
`define OSW_PRESC_RST    8'h00
`define OSW_EDGE_RST     4'h0

`endif

// *** verilog/osw_pkg.sv ***
// Purpose: types shared by the one-shot / width-capture timer
// Assumes: nothing
// Notes:   constants live in osw_cfg.svh
package osw_pkg;

    // ------------------------------------------------------------
    // one-shot sequencer, gray along idle -> delay -> active
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OSW_IDLE   = 2'b00,   // no pulse pending
        OSW_DELAY  = 2'b01,   // waiting for first compare
        OSW_ACTIVE = 2'b11    // active level out, waiting for second
    } osw_os_state_type;

    // output control fields
    typedef struct packed {
        logic os_enable;      // one-shot enable
        logic inv_cmp1;       // toggle on compare 1
        logic inv_cmp0;       // toggle on compare 0
        logic pin_enable;     // drive pin
    } osw_outctl_type;

    // capture/compare control fields
    typedef struct packed {
        logic cap1;           // register 1 captures
        logic src0_opp;       // register 0 source: opposite edge of input 0
        logic cap0;           // register 0 captures
    } osw_ccctl_type;

endpackage

// *** verilog/osw_timer.sv ***
// Purpose: 16-bit timer channel with one-shot pulse output and pulse width capture
// Assumes: inputs synchronous to ref_clk; Avalon-MM slave with word addresses
// Notes:   count clock is a one-cycle enable from a programmable divider
`timescale 1ns/1ps
`include "osw_cfg.svh"

module osw_timer
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        capture_input_0,
    input  wire logic        capture_input_1,
    output logic             timer_output_pin,
    output logic             irq_ch0,
    output logic             irq_ch1
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0]  rst_sync_q;       // release shifter
    logic        rst_n;            // synchronised reset

    // asserts at once, releases after two edges
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0]                 mode_q;       // mode field
    logic                       ovf_q;        // overflow flag
    osw_pkg::osw_ccctl_type     cc_q;         // capture/compare control
    osw_pkg::osw_outctl_type    oc_q;         // output control
    logic [3:0]                 edge_q;       // [1:0] input 0, [3:2] input 1
    logic [7:0]                 presc_q;      // divider reload
    logic [15:0]                count_q;      // counter
    logic [15:0]                cc0_q;        // capture/compare 0
    logic [15:0]                cc1_q;        // capture/compare 1
    logic                       wreq;         // write accepted this edge
    logic                       run;          // counter operating

    assign wreq = write && !waitrequest;
    assign run  = (mode_q != `OSW_MODE_STOP);

    // bus handshake: one wait cycle, then acknowledge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            waitrequest <= 1'b1;
        else
            waitrequest <= !((read || write) && waitrequest);
    end

    // read data captured during the wait cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            readdata <= 32'h0000_0000;
        else if (read && waitrequest)
        begin
            unique case (address)
                `OSW_IDX_MODE:   readdata <= {28'h000_0000, mode_q, 1'b0, ovf_q};
                `OSW_IDX_CCCTL:  readdata <= {29'h0000_0000, cc_q};
                `OSW_IDX_OUTCTL: readdata <= {26'h000_0000, oc_q.os_enable, oc_q.inv_cmp1,
                                              2'b00, oc_q.inv_cmp0, oc_q.pin_enable};
                `OSW_IDX_EDGE:   readdata <= {28'h000_0000, edge_q};
                `OSW_IDX_PRESC:  readdata <= {24'h00_0000, presc_q};
                `OSW_IDX_COUNT:  readdata <= {16'h0000, count_q};
                `OSW_IDX_CC0:    readdata <= {16'h0000, cc0_q};
                `OSW_IDX_CC1:    readdata <= {16'h0000, cc1_q};
                default:         readdata <= 32'h0000_0000;        // unmapped reads zero
            endcase
        end
    end

    // plain control registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q  <= `OSW_MODE_STOP;
            cc_q    <= '0;
            oc_q    <= '0;
            edge_q  <= `OSW_EDGE_RST;
            presc_q <= `OSW_PRESC_RST;
        end
        else if (wreq)
        begin
            unique case (address)
                `OSW_IDX_MODE:   mode_q  <= writedata[`OSW_MODE_LO_BIT +: 2];
                `OSW_IDX_CCCTL:  cc_q    <= writedata[2:0];
                `OSW_IDX_OUTCTL: oc_q    <= {writedata[`OSW_OC_OSEN_BIT], writedata[`OSW_OC_INV1_BIT],
                                             writedata[`OSW_OC_INV0_BIT], writedata[`OSW_OC_PINEN_BIT]};
                `OSW_IDX_EDGE:   edge_q  <= writedata[3:0];
                `OSW_IDX_PRESC:  presc_q <= writedata[7:0];
                default:         ;                               // other writes ignored
            endcase
        end
    end

    // ------------------------------------------------------------
    // count clock divider
    // ------------------------------------------------------------
    logic [7:0] div_q;     // down counter
    logic       tick;      // count clock enable

    assign tick = run && (div_q == 8'h00);

    // reloads with prescale value on each tick and on every cycle while stopped
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= 8'h00;
        else if (!run || tick)
            div_q <= presc_q;
        else
            div_q <= div_q - 8'h01;
    end

    // ------------------------------------------------------------
    // edge detection and triggers
    // ------------------------------------------------------------
    logic in0_q;             // previous input 0
    logic in1_q;             // previous input 1
    logic in0_valid;         // selected edge on input 0
    logic in0_opp;           // opposite edge on input 0
    logic in1_valid;         // selected edge on input 1
    logic soft_trig;         // software one-shot trigger
    logic os_allowed;        // one-shot output permitted
    logic os_trig;           // accepted one-shot trigger

    // edge code: 00 falling, 01 rising, 1x both
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        logic rise;
        logic fall;
        rise = !prev && cur;
        fall = prev && !cur;
        edge_hit = sel[1] ? (rise || fall) : (sel[0] ? rise : fall);
    endfunction

    // previous levels, inputs already synchronous
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in0_q <= 1'b0;
            in1_q <= 1'b0;
        end
        else
        begin
            in0_q <= capture_input_0;
            in1_q <= capture_input_1;
        end
    end

    assign in0_valid  = run && edge_hit(edge_q[1:0], in0_q, capture_input_0);
    assign in0_opp    = run && !edge_q[1] && edge_hit(~edge_q[1:0] & 2'b01, in0_q, capture_input_0);
    assign in1_valid  = run && edge_hit(edge_q[3:2], in1_q, capture_input_1);
    assign soft_trig  = wreq && (address == `OSW_IDX_OUTCTL) && writedata[`OSW_OC_OSTRG_BIT];
    assign os_allowed = oc_q.os_enable && ((mode_q == `OSW_MODE_FREE) ||
                        (mode_q == `OSW_MODE_IN0CLR));
    assign os_trig    = os_allowed && (soft_trig || in0_valid);

    // ------------------------------------------------------------
    // counter, overflow, captures
    // ------------------------------------------------------------
    logic        clr_pend_q;    // clear at next tick
    logic        cap0_ev;       // capture into register 0
    logic        cap1_ev;       // capture into register 1
    logic        cap0_irq;      // capture 0 wants an interrupt
    logic        wrap;          // counter wraps this tick
    logic        match0;        // compare 0 hit this tick
    logic        match1;        // compare 1 hit this tick
    logic [15:0] cnt_d;         // next count

    assign cap1_ev  = cc_q.cap1 && in0_valid;
    assign cap0_ev  = cc_q.cap0 && (cc_q.src0_opp ? in0_opp : in1_valid);
    assign cap0_irq = cap0_ev && !cc_q.src0_opp;
    assign wrap     = tick && !clr_pend_q && (count_q == `OSW_CNT_MAX);
    assign cnt_d    = clr_pend_q ? `OSW_CNT_ZERO : count_q + 16'h0001;
    assign match0   = tick && !cc_q.cap0 && (cnt_d == cc0_q);
    assign match1   = tick && !cc_q.cap1 && (cnt_d == cc1_q);

    // clear request from one-shot trigger or mode-10 valid edge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            clr_pend_q <= 1'b0;
        else if (os_trig || (in0_valid && mode_q == `OSW_MODE_IN0CLR))
            clr_pend_q <= 1'b1;
        else if (!run || tick)
            clr_pend_q <= 1'b0;                                         // a new request wins over the clear
    end

    // counter runs on ticks, sits at zero while stopped
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= `OSW_CNT_ZERO;
        else if (!run)
            count_q <= `OSW_CNT_ZERO;
        else if (tick)
            count_q <= cnt_d;
    end

    // overflow flag: software clears by writing 0, a wrap wins
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ovf_q <= 1'b0;
        else if (wrap)
            ovf_q <= 1'b1;
        else if (wreq && address == `OSW_IDX_MODE && !writedata[`OSW_MODE_OVF_BIT])
            ovf_q <= 1'b0;
    end

    // capture/compare registers: capture in hardware, compare value from software
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cc0_q <= `OSW_CNT_ZERO;
            cc1_q <= `OSW_CNT_ZERO;
        end
        else
        begin
            if (cap0_ev)
                cc0_q <= count_q;
            else if (wreq && address == `OSW_IDX_CC0)
                cc0_q <= writedata[15:0];
            if (cap1_ev)
                cc1_q <= count_q;
            else if (wreq && address == `OSW_IDX_CC1)
                cc1_q <= writedata[15:0];
        end
    end

    // ------------------------------------------------------------
    // interrupts: capture requests wait for the next tick
    // ------------------------------------------------------------
    logic pend0_q;     // capture 0 interrupt pending
    logic pend1_q;     // capture 1 interrupt pending

    // pending captures, a new capture wins over delivery
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend0_q <= 1'b0;
            pend1_q <= 1'b0;
        end
        else
        begin
            pend0_q <= run && (cap0_irq || (pend0_q && !tick));
            pend1_q <= run && (cap1_ev || (pend1_q && !tick));
        end
    end

    // one-cycle interrupt pulses
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_ch0 <= 1'b0;
            irq_ch1 <= 1'b0;
        end
        else
        begin
            irq_ch0 <= match0 || (pend0_q && tick);
            irq_ch1 <= match1 || (pend1_q && tick);
        end
    end

    // ------------------------------------------------------------
    // one-shot sequencer and output level
    // ------------------------------------------------------------
    osw_pkg::osw_os_state_type os_q;   // one-shot phase
    logic                      lvl_q;  // output level before enable
    logic                      tog;    // toggle this tick

    // idle -> delay on trigger, first match -> active, second -> idle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            os_q <= osw_pkg::OSW_IDLE;
        else if (!os_allowed)
            os_q <= osw_pkg::OSW_IDLE;
        else
        begin
            unique case (os_q)
                osw_pkg::OSW_IDLE:   if (os_trig) os_q <= osw_pkg::OSW_DELAY;
                osw_pkg::OSW_DELAY:  if (match0 || match1) os_q <= osw_pkg::OSW_ACTIVE;
                osw_pkg::OSW_ACTIVE: if (match0 || match1) os_q <= osw_pkg::OSW_IDLE;
                default:             os_q <= osw_pkg::OSW_IDLE;
            endcase
        end
    end

    // one-shot permitted: toggle on either match while armed, none while idle; else per invert bits
    assign tog = os_allowed ? ((os_q != osw_pkg::OSW_IDLE) && (match0 || match1))
                            : ((match0 && oc_q.inv_cmp0) || (match1 && oc_q.inv_cmp1));

    // output level and pin drive
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvl_q            <= 1'b0;
            timer_output_pin <= 1'b0;
        end
        else
        begin
            lvl_q            <= lvl_q ^ tog;
            timer_output_pin <= oc_q.pin_enable && (lvl_q ^ tog);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    stop_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !run |=> count_q == `OSW_CNT_ZERO) else $error("counter moved while stopped");
    wrap_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrap |=> ovf_q) else $error("wrap did not set overflow");
    ovf_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ovf_q && !(wreq && address == `OSW_IDX_MODE) |=> ovf_q) else $error("overflow cleared by itself");
    cmp0_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        match0 |=> irq_ch0) else $error("compare 0 gave no interrupt");
    os_toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        os_allowed && os_q == osw_pkg::OSW_ACTIVE && match1 |=> lvl_q != $past(lvl_q))
        else $error("compare 1 did not end pulse");
    os_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        os_q != osw_pkg::OSW_IDLE |-> $past(oc_q.os_enable)) else $error("one-shot armed while disabled");
    cap1_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cap1_ev |=> cc1_q == $past(count_q)) else $error("capture 1 took wrong count");
    opp_noirq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cap0_ev && cc_q.src0_opp && !pend0_q |=> !pend0_q) else $error("opposite edge raised interrupt");
    count_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        read && waitrequest && address == `OSW_IDX_COUNT |=> readdata[15:0] == $past(count_q))
        else $error("count read mismatch");
    trig_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clr_pend_q && tick |=> count_q == `OSW_CNT_ZERO) else $error("trigger did not clear");

endmodule
